// [hdl/ibdma_pkg.sv]
// Constants, register map and state encoding of the ISA bridge DMA block
package ibdma_pkg;
	localparam int ADDR_W = 6;
	localparam int MADDR_W = 27;
	localparam int CNT_W = 16;
	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [5:0] OFS_CMD = 6'h00;
	localparam logic [5:0] OFS_SWREQ = 6'h01;
	localparam logic [5:0] OFS_MASK = 6'h02;
	localparam logic [5:0] OFS_STATUS = 6'h03;
	localparam logic [2:0] GRP_MODE = 3'h1;
	localparam logic [2:0] GRP_BASE_ADDR = 3'h2;
	localparam logic [2:0] GRP_BASE_CNT = 3'h3;
	localparam logic [2:0] GRP_CUR_ADDR = 3'h4;
	localparam logic [2:0] GRP_CUR_CNT = 3'h5;
	// ****************************************
	// Fields and reset values
	// ****************************************
	localparam int CMD_ROTATE = 0;
	localparam int CMD_REQ_LOW = 1;
	localparam int CMD_ACK_HIGH = 2;
	localparam int CMD_DISABLE = 3;
	localparam logic [3:0] CMD_RST = 4'h0;
	localparam logic [7:0] MASK_RST = 8'hef;
	localparam int MODE_AUTO = 2;
	localparam int MODE_DEC = 3;
	localparam logic [1:0] XT_VERIFY = 2'h0;
	localparam logic [1:0] XT_WRITE = 2'h1;
	localparam logic [1:0] XT_READ = 2'h2;
	localparam logic [1:0] MD_DEMAND = 2'h0;
	localparam logic [1:0] MD_SINGLE = 2'h1;
	localparam logic [1:0] MD_BLOCK = 2'h2;
	localparam logic [1:0] MD_CASCADE = 2'h3;
	localparam logic [5:0] MODE_RST = 6'h10;
	localparam logic [5:0] MODE_CASC_RST = 6'h30;
	localparam int CASC_CH = 4;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_NS = 25;
	localparam int STROBE_NS = 250;
	localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
	localparam int REFRESH_NS = 15000;
	localparam int REFRESH_CYC = REFRESH_NS / CLK_NS;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_ACK = 3'h1,
		ST_XFER = 3'h3,
		ST_DONE = 3'h2,
		ST_CASC = 3'h6,
		ST_REFR = 3'h4
	} ibdma_state_type;
endpackage

// [hdl/ibdma_top.sv]
// Seven-channel cascaded DMA engine with refresh generator and register port
`timescale 1ns/100ps
module ibdma_top #(
	parameter int STROBE_CYCLES = ibdma_pkg::STROBE_CYC,
	parameter int REFRESH_CYCLES = ibdma_pkg::REFRESH_CYC
) (
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic [ibdma_pkg::ADDR_W-1:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	input wire logic [7:0] dreq_in,
	input wire logic chrdy_in,
	input wire logic refresh_n_in,
	output logic [7:0] dack_out,
	output logic tc_out,
	output logic aen_out,
	output logic [ibdma_pkg::MADDR_W-1:0] mem_addr_out,
	output logic word_xfer_out,
	output logic memr_n_out,
	output logic memw_n_out,
	output logic smemr_n_out,
	output logic smemw_n_out,
	output logic ior_n_out,
	output logic iow_n_out,
	output logic refresh_n_out,
	output logic refresh_oe_out
);
	import ibdma_pkg::*;

	if (STROBE_CYCLES < 1 || STROBE_CYCLES > 255)
		$error("STROBE_CYCLES out of range");
	if (REFRESH_CYCLES < 4 || REFRESH_CYCLES > 65535)
		$error("REFRESH_CYCLES out of range");

	// ****************************************
	// Register storage
	// ****************************************
	logic [3:0] cmd_r;
	logic [7:0] swreq_r;
	logic [7:0] mask_r;
	logic [7:0] tcflag_r;
	logic [5:0] mode_r [8];
	logic [MADDR_W-1:0] base_addr_r [8];
	logic [CNT_W-1:0] base_cnt_r [8];
	logic [MADDR_W-1:0] cur_addr_r [8];
	logic [CNT_W-1:0] cur_cnt_r [8];
	logic [31:0] rdata_r;

	// ****************************************
	// Request synchroniser and arbitration
	// ****************************************
	logic [7:0] sync1_r;
	logic [7:0] sync2_r;
	logic [1:0] last_lo_r;
	logic [1:0] last_hi_r;

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			sync1_r <= 8'h00;
			sync2_r <= 8'h00;
		end else begin
			sync1_r <= dreq_in;
			sync2_r <= sync1_r;
		end
	end

	// Polarity is applied after the second flop so the first stays clean
	wire [7:0] hw_req = cmd_r[CMD_REQ_LOW] ? ~sync2_r : sync2_r;
	wire [7:0] any_req = (hw_req | swreq_r) & 8'hef;
	wire [7:0] elig = any_req & ~mask_r;
	wire lo_any = |elig[3:0];
	wire [3:0] hi_vec = {elig[7:5], lo_any & ~mask_r[CASC_CH]};

	function automatic logic [2:0] ibdma_arb(input logic [3:0] req,
		input logic [1:0] last);
		logic [2:0] pick;
		logic [1:0] idx;
		pick = 3'h0;
		for (int i = 4; i >= 1; i--) begin
			idx = last + 2'(i);
			if (req[idx])
				pick = {1'b1, idx};
		end
		return pick;
	endfunction

	// Fixed priority keeps the pointers at 3 so index 0 always leads
	wire [2:0] arb_lo = ibdma_arb(elig[3:0], last_lo_r);
	wire [2:0] arb_hi = ibdma_arb(hi_vec, last_hi_r);
	wire grant_ok = arb_hi[2] & ~cmd_r[CMD_DISABLE];
	wire [2:0] grant_ch = (arb_hi[1:0] == 2'h0) ?
		{1'b0, arb_lo[1:0]} : {1'b1, arb_hi[1:0]};

	// ****************************************
	// Transfer engine
	// ****************************************
	ibdma_state_type state_r;
	ibdma_state_type state_nxt;
	logic [2:0] ch_r;
	logic [7:0] tmr_r;
	logic [15:0] ref_tmr_r;
	logic ref_pend_r;
	logic [7:0] ref_addr_r;

	wire [5:0] cur_mode = mode_r[ch_r];
	wire [1:0] cur_md = cur_mode[5:4];
	wire [1:0] cur_xt = cur_mode[1:0];
	wire is_word = ch_r[2];
	wire [MADDR_W-1:0] ch_addr = cur_addr_r[ch_r];
	wire [MADDR_W-1:0] byte_addr = is_word ?
		{ch_addr[MADDR_W-2:0], 1'b0} : ch_addr;
	wire last_xfer = (cur_cnt_r[ch_r] == '0);
	wire ch_req = any_req[ch_r];
	wire below_16m = (byte_addr[26:24] == 3'h0);
	wire below_1m = (byte_addr[26:20] == 7'h00);
	wire tmr_done = (tmr_r == 8'h01) & chrdy_in;
	wire grant_casc = (mode_r[grant_ch][5:4] == MD_CASCADE);

	// Continuation after one transfer depends on mode
	wire keep_going = ~last_xfer & ~cmd_r[CMD_DISABLE] &
		((cur_md == MD_BLOCK) | ((cur_md == MD_DEMAND) & ch_req));

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (ref_pend_r && refresh_n_in)
					state_nxt = ST_REFR;
				else if (grant_ok && grant_casc)
					state_nxt = ST_CASC;
				else if (grant_ok)
					state_nxt = ST_ACK;
			end
			ST_ACK: state_nxt = ST_XFER;
			ST_XFER: begin
				if (tmr_done)
					state_nxt = ST_DONE;
			end
			ST_DONE: state_nxt = keep_going ? ST_ACK : ST_IDLE;
			ST_CASC: begin
				if (!ch_req)
					state_nxt = ST_IDLE;
			end
			ST_REFR: begin
				if (tmr_done)
					state_nxt = ST_IDLE;
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	wire start_ch = (state_r == ST_IDLE) && (state_nxt == ST_ACK ||
		state_nxt == ST_CASC);
	wire load_tmr = (state_nxt == ST_XFER && state_r != ST_XFER) ||
		(state_nxt == ST_REFR && state_r != ST_REFR);
	wire xfer_end = (state_r == ST_DONE);
	wire [7:0] strobe_len = 8'(STROBE_CYCLES);

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_r <= ST_IDLE;
			ch_r <= 3'h0;
			tmr_r <= 8'h00;
		end else begin
			state_r <= state_nxt;
			if (start_ch)
				ch_r <= grant_ch;
			if (load_tmr)
				tmr_r <= strobe_len;
			else if (tmr_r > 8'h01)
				tmr_r <= tmr_r - 8'h01;
		end
	end

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			last_lo_r <= 2'h3;
			last_hi_r <= 2'h3;
		end else if (!cmd_r[CMD_ROTATE]) begin
			last_lo_r <= 2'h3;
			last_hi_r <= 2'h3;
		end else if (start_ch) begin
			if (!grant_ch[2])
				last_lo_r <= grant_ch[1:0];
			last_hi_r <= grant_ch[2] ? grant_ch[1:0] : 2'h0;
		end
	end

	// ****************************************
	// Refresh request divider
	// ****************************************
	wire ref_tick = (ref_tmr_r == 16'h0000);
	wire ref_take = (state_r == ST_REFR) && tmr_done;
	// An external master's refresh also advances the row counter
	logic ext_ref_d_r;
	wire ext_ref_end = ~ext_ref_d_r & refresh_n_in & ~refresh_oe_out;

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ref_tmr_r <= 16'h0000;
			ref_pend_r <= 1'b0;
			ref_addr_r <= 8'h00;
			ext_ref_d_r <= 1'b1;
		end else begin
			ext_ref_d_r <= refresh_n_in | refresh_oe_out;
			ref_tmr_r <= ref_tick ? 16'(REFRESH_CYCLES - 1) :
				ref_tmr_r - 16'h0001;
			if (ref_tick)
				ref_pend_r <= 1'b1;
			else if (ref_take)
				ref_pend_r <= 1'b0;
			if (ref_take || ext_ref_end)
				ref_addr_r <= ref_addr_r + 8'h01;
		end
	end

	// ****************************************
	// Register port and channel state
	// ****************************************
	wire [2:0] reg_grp = reg_addr_in[5:3];
	wire [2:0] reg_ch = reg_addr_in[2:0];
	wire wr_cmd = reg_wr_in && reg_addr_in == OFS_CMD;
	wire wr_swreq = reg_wr_in && reg_addr_in == OFS_SWREQ;
	wire wr_mask = reg_wr_in && reg_addr_in == OFS_MASK;
	wire rd_status = reg_rd_in && reg_addr_in == OFS_STATUS;
	wire wr_mode = reg_wr_in && reg_grp == GRP_MODE;
	wire wr_baddr = reg_wr_in && reg_grp == GRP_BASE_ADDR;
	wire wr_bcnt = reg_wr_in && reg_grp == GRP_BASE_CNT;
	wire [MADDR_W-1:0] addr_step = cur_mode[MODE_DEC] ?
		ch_addr - 27'h0000001 : ch_addr + 27'h0000001;
	wire done_tc = xfer_end && last_xfer;
	wire reload = done_tc && cur_mode[MODE_AUTO];
	wire [7:0] ch_bit = 8'h01 << ch_r;

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cmd_r <= CMD_RST;
			swreq_r <= 8'h00;
			mask_r <= MASK_RST;
			tcflag_r <= 8'h00;
		end else begin
			if (wr_cmd)
				cmd_r <= reg_wdata_in[3:0];
			// Terminal count clears the request; a new write still wins
			swreq_r <= (swreq_r & ~(done_tc ? ch_bit : 8'h00)) |
				(wr_swreq ? reg_wdata_in[7:0] : 8'h00);
			// A count ending in the cycle of a mask write still masks
			mask_r <= (wr_mask ? reg_wdata_in[7:0] : mask_r) |
				((done_tc && !cur_mode[MODE_AUTO]) ? ch_bit : 8'h00);
			// Reading status clears it, but a count ending now survives
			tcflag_r <= (rd_status ? 8'h00 : tcflag_r) |
				(done_tc ? ch_bit : 8'h00);
		end
	end

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			for (int i = 0; i < 8; i++) begin
				mode_r[i] <= (i == CASC_CH) ? MODE_CASC_RST : MODE_RST;
				base_addr_r[i] <= '0;
				base_cnt_r[i] <= '0;
				cur_addr_r[i] <= '0;
				cur_cnt_r[i] <= '0;
			end
		end else begin
			if (wr_mode)
				mode_r[reg_ch] <= reg_wdata_in[5:0];
			if (wr_baddr) begin
				base_addr_r[reg_ch] <= reg_wdata_in[MADDR_W-1:0];
				cur_addr_r[reg_ch] <= reg_wdata_in[MADDR_W-1:0];
			end else if (xfer_end) begin
				cur_addr_r[ch_r] <= reload ? base_addr_r[ch_r] : addr_step;
			end
			if (wr_bcnt) begin
				base_cnt_r[reg_ch] <= reg_wdata_in[CNT_W-1:0];
				cur_cnt_r[reg_ch] <= reg_wdata_in[CNT_W-1:0];
			end else if (xfer_end) begin
				cur_cnt_r[ch_r] <= reload ? base_cnt_r[ch_r] :
					cur_cnt_r[ch_r] - 16'h0001;
			end
		end
	end

	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h00000000;
		case (reg_grp)
			3'h0: begin
				case (reg_ch)
					3'h0: rd_mux = {28'h0000000, cmd_r};
					3'h1: rd_mux = {24'h000000, swreq_r};
					3'h2: rd_mux = {24'h000000, mask_r};
					3'h3: rd_mux = {16'h0000, elig, tcflag_r};
					default: rd_mux = 32'h00000000;
				endcase
			end
			GRP_MODE: rd_mux = {26'h0000000, mode_r[reg_ch]};
			GRP_BASE_ADDR: rd_mux = {5'h00, base_addr_r[reg_ch]};
			GRP_BASE_CNT: rd_mux = {16'h0000, base_cnt_r[reg_ch]};
			GRP_CUR_ADDR: rd_mux = {5'h00, cur_addr_r[reg_ch]};
			GRP_CUR_CNT: rd_mux = {16'h0000, cur_cnt_r[reg_ch]};
			default: rd_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in)
			rdata_r <= 32'h00000000;
		else
			rdata_r <= reg_rd_in ? rd_mux : 32'h00000000;
	end
	assign reg_rdata_out = rdata_r;

	// ****************************************
	// Bus outputs
	// ****************************************
	wire in_dma = (state_r == ST_ACK) || (state_r == ST_XFER) ||
		(state_r == ST_DONE);
	wire in_ref = (state_r == ST_REFR);
	wire strobe = (state_r == ST_XFER);
	// Verify moves no data, so neither side sees a command
	wire do_wr = strobe && cur_xt == XT_WRITE;
	wire do_rd = strobe && cur_xt == XT_READ;
	wire dack_act = in_dma || (state_r == ST_CASC);
	wire [7:0] dack_vec = dack_act ? ch_bit : 8'h00;

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			dack_out <= 8'hff;
			tc_out <= 1'b0;
			aen_out <= 1'b0;
			mem_addr_out <= '0;
			word_xfer_out <= 1'b0;
			memr_n_out <= 1'b1;
			memw_n_out <= 1'b1;
			smemr_n_out <= 1'b1;
			smemw_n_out <= 1'b1;
			ior_n_out <= 1'b1;
			iow_n_out <= 1'b1;
			refresh_n_out <= 1'b1;
			refresh_oe_out <= 1'b0;
		end else begin
			dack_out <= cmd_r[CMD_ACK_HIGH] ? dack_vec : ~dack_vec;
			tc_out <= strobe && last_xfer;
			aen_out <= in_dma || in_ref;
			mem_addr_out <= in_ref ? {19'h00000, ref_addr_r} : byte_addr;
			word_xfer_out <= in_dma && is_word;
			memr_n_out <= ~((do_rd && below_16m) || in_ref);
			memw_n_out <= ~(do_wr && below_16m);
			smemr_n_out <= ~((do_rd && below_1m) || in_ref);
			smemw_n_out <= ~(do_wr && below_1m);
			ior_n_out <= ~do_wr;
			iow_n_out <= ~do_rd;
			refresh_n_out <= ~in_ref;
			refresh_oe_out <= in_ref;
		end
	end
endmodule

// [dv/ibdma_chk.sv]
// Port-level assertion checker for the ISA bridge DMA block
`timescale 1ns/100ps
module ibdma_chk
	import ibdma_pkg::*;
#(
	parameter int STROBE_CYCLES = 10
) (
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic [7:0] dreq_in,
	input wire logic [7:0] dack_out,
	input wire logic tc_out,
	input wire logic aen_out,
	input wire logic [ibdma_pkg::MADDR_W-1:0] mem_addr_out,
	input wire logic word_xfer_out,
	input wire logic memr_n_out,
	input wire logic memw_n_out,
	input wire logic smemr_n_out,
	input wire logic smemw_n_out,
	input wire logic ior_n_out,
	input wire logic iow_n_out,
	input wire logic refresh_n_out,
	input wire logic refresh_oe_out
);
	logic io_low;
	int low_cnt_r;
	assign io_low = !ior_n_out || !iow_n_out;
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			low_cnt_r <= 0;
		end else begin
			low_cnt_r <= io_low ? low_cnt_r + 1 : 0;
		end
	end
	// ********
	// Assertions
	// ********
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!resetn_in);
	one_grant_a: assert property ($onehot0(~dack_out) && dack_out[4])
		else $error("more than one acknowledge active");
	reset_idle_a: assert property (disable iff (1'h0)
		!resetn_in |-> dack_out == 8'hff && !tc_out && !refresh_oe_out)
		else $error("outputs not idle in reset");
	high_mem_a: assert property (!memr_n_out || !memw_n_out |->
		mem_addr_out < 27'h1000000) else $error("memory strobe above 16M");
	low_mem_a: assert property (!smemr_n_out || !smemw_n_out |->
		mem_addr_out < 27'h100000) else $error("low strobe above 1M");
	no_m2m_a: assert property (!(!memr_n_out && !memw_n_out) &&
		!(!ior_n_out && !iow_n_out)) else $error("both directions at once");
	dma_aen_a: assert property (io_low |-> aen_out && dack_out != 8'hff)
		else $error("strobe without address enable or grant");
	refresh_a: assert property (refresh_oe_out |-> !refresh_n_out &&
		!memr_n_out && aen_out && dack_out == 8'hff)
		else $error("refresh drive without refresh cycle");
	strobe_len_a: assert property ($fell(io_low) |->
		low_cnt_r >= STROBE_CYCLES) else $error("strobe too short");
	tc_grant_a: assert property (tc_out |-> dack_out != 8'hff && aen_out)
		else $error("terminal count outside service");
	word_addr_a: assert property (word_xfer_out |-> !mem_addr_out[0] &&
		dack_out[7:5] != 3'h7) else $error("word transfer address odd");
	sync_wait_a: assert property ($rose(dreq_in[1]) && dack_out == 8'hff
		|-> ##1 dack_out[1] [*3]) else $error("request granted unsynchronised");
	tc_c: cover property ($rose(tc_out));
	refr_c: cover property ($rose(refresh_oe_out));
	word_c: cover property ($rose(word_xfer_out));
endmodule
bind ibdma_top ibdma_chk #(.STROBE_CYCLES(STROBE_CYCLES)) ibdma_chk_i (.*);

// [dv/ibdma_isa_dev.sv]
// Behavioural ISA slave: request lines and channel ready
`timescale 1ns/100ps
module ibdma_isa_dev (
	input wire logic clk_in,
	input wire logic [7:0] go_in,
	input wire logic slow_in,
	input wire logic [7:0] dack_n_in,
	input wire logic strobe_in,
	output logic [7:0] dreq_out,
	output logic chrdy_out,
	output logic refresh_n_out
);
	int wait_r = 0;
	initial dreq_out = 8'h0;
	always @(posedge clk_in) begin
		// Request stays up until its acknowledge shows
		dreq_out <= (dreq_out | go_in) & dack_n_in;
		wait_r <= strobe_in ? wait_r + 1 : 0;
	end
	// Slow device holds off the first three strobe cycles
	assign chrdy_out = !slow_in || wait_r >= 3;
	// Line is pulled up; this device never starts refresh
	assign refresh_n_out = 1'h1;
endmodule

// [dv/ibdma_bench.sv]
// Self-checking bench for the ISA bridge DMA block
`timescale 1ns/100ps
`define CHK(n, e, s) begin cmp_count++; if ((e) !== (s)) begin failures++; \
	$display("BAD %s exp %0h got %0h", n, e, s); end end
module ibdma_bench;
	import ibdma_pkg::*;
	logic clk_sys_in = 1'h0;
	logic resetn_in = 1'h1;
	logic [ADDR_W-1:0] reg_addr_in = '0;
	logic [31:0] reg_wdata_in = '0;
	logic reg_wr_in = 1'h0;
	logic reg_rd_in = 1'h0;
	logic [31:0] reg_rdata_out;
	logic [7:0] dreq_in, dack_out, go = 8'h0;
	logic chrdy_in, refresh_n_in, slow = 1'h0, io_q = 1'h0;
	logic tc_out, aen_out, word_xfer_out, memr_n_out, memw_n_out;
	logic smemr_n_out, smemw_n_out, ior_n_out, iow_n_out;
	logic refresh_n_out, refresh_oe_out;
	logic [MADDR_W-1:0] mem_addr_out, a;
	logic [33:0] seen, e, exp_q[$];
	logic [31:0] d;
	int failures = 0, cmp_count = 0, seed = 18384;
	always #12.5 clk_sys_in = ~clk_sys_in;
	// Short strobe and refresh interval keep the run brief
	ibdma_top #(.STROBE_CYCLES(4), .REFRESH_CYCLES(200)) ibdma_top_i (.*);
	ibdma_isa_dev ibdma_isa_dev_i (.clk_in(clk_sys_in), .go_in(go),
		.slow_in(slow), .dack_n_in(dack_out),
		.strobe_in(!ior_n_out || !iow_n_out), .dreq_out(dreq_in),
		.chrdy_out(chrdy_in), .refresh_n_out(refresh_n_in));
	// ********
	// Transfer model
	// ********
	always @(posedge clk_sys_in) begin
		io_q <= !ior_n_out || !iow_n_out;
		if (!ior_n_out || !iow_n_out) begin
			seen = {tc_out, ior_n_out, iow_n_out, memr_n_out, memw_n_out,
				smemr_n_out, smemw_n_out, mem_addr_out};
		end
		if (io_q && ior_n_out && iow_n_out) begin
			e = exp_q.pop_front();
			`CHK("xfer", e, seen)
		end
	end
	task automatic wreg(input logic [5:0] ad, input logic [31:0] wd);
		@(posedge clk_sys_in);
		reg_addr_in <= ad;
		reg_wdata_in <= wd;
		reg_wr_in <= 1'h1;
		@(posedge clk_sys_in);
		reg_wr_in <= 1'h0;
	endtask
	task automatic rreg(input logic [5:0] ad, output logic [31:0] rd);
		@(posedge clk_sys_in);
		reg_addr_in <= ad;
		reg_rd_in <= 1'h1;
		@(posedge clk_sys_in);
		reg_rd_in <= 1'h0;
		#1 rd = reg_rdata_out;
	endtask
	task automatic prog(input logic [5:0] ch, input logic [5:0] mv,
		input logic [26:0] ba, input int cnt);
		logic [26:0] o;
		logic wr, hi, lo;
		wreg(6'h08 + ch, {26'h0, mv});
		wreg(6'h10 + ch, {5'h0, ba});
		wreg(6'h18 + ch, cnt);
		for (int i = 0; i <= cnt && mv[1:0] != XT_VERIFY; i++) begin
			o = ch > 4 ? ba << 1 : ba;
			wr = mv[1:0] == XT_WRITE;
			hi = o < 27'h1000000;
			lo = o < 27'h100000;
			exp_q.push_back({i == cnt, !wr, wr, !(!wr && hi), !(wr && hi),
				!(!wr && lo), !(wr && lo), o});
			ba = mv[MODE_DEC] ? ba - 1 : ba + 1;
		end
	endtask
	task automatic fire(input logic [7:0] chs, input logic sw,
		input logic [7:0] msk);
		logic [7:0] st;
		st = 8'h0;
		wreg(OFS_MASK, {24'h0, MASK_RST & ~chs});
		if (sw) begin
			wreg(OFS_SWREQ, {24'h0, chs});
		end else begin
			@(posedge clk_sys_in) go <= chs;
			@(posedge clk_sys_in) go <= 8'h0;
		end
		for (int k = 0; k < 400 && st != chs; k++) begin
			rreg(OFS_STATUS, d);
			st = st | d[7:0];
		end
		repeat (4) @(posedge clk_sys_in);
		`CHK("tc", chs, st)
		`CHK("left", 0, exp_q.size())
		rreg(OFS_MASK, d);
		`CHK("mask", msk, d[7:0])
	endtask
	task automatic test_done;
		if (failures == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// ********
	// Scenarios
	// ********
	initial begin
		#(25 * 40000);
		failures++;
		test_done;
	end
	initial begin
		resetn_in <= 1'h0;
		repeat (5) @(posedge clk_sys_in);
		resetn_in <= 1'h1;
		`CHK("dack", 8'hff, dack_out)
		rreg(OFS_CMD, d);
		`CHK("cmd", 32'h0, d)
		rreg(OFS_MASK, d);
		`CHK("mask0", 32'hef, d)
		rreg(6'h0c, d);
		`CHK("mode4", 32'h30, d)
		rreg(6'h3f, d);
		`CHK("hole", 32'h0, d)
		// Byte block write below 1M, hardware request
		a = 27'($random(seed));
		a[26:18] = '0;
		prog(6'h1, 6'h21, a, 2);
		fire(8'h02, 1'h0, 8'hef);
		// Single read, decrementing, above 1M, software request
		a = 27'($random(seed));
		a[26:23] = 4'h1;
		prog(6'h3, 6'h1a, a, 1);
		fire(8'h08, 1'h1, 8'hef);
		// Word demand write above 16M with a slow device
		slow <= 1'h1;
		a = 27'($random(seed));
		a[26:25] = 2'h1;
		prog(6'h5, 6'h01, a, 1);
		fire(8'h20, 1'h1, 8'hef);
		slow <= 1'h0;
		// Verify with auto-initialisation keeps the channel live
		a = 27'($random(seed));
		prog(6'h7, 6'h24, a, 3);
		fire(8'h80, 1'h0, 8'h6f);
		rreg(6'h2f, d);
		`CHK("recount", 32'h3, d)
		rreg(6'h27, d);
		`CHK("readdr", {5'h0, a}, d)
		// Two requests at once: channel 0 is served whole first
		a = 27'($random(seed));
		a[26:18] = '0;
		prog(6'h0, 6'h22, a, 1);
		prog(6'h2, 6'h22, a + 27'h40, 1);
		fire(8'h05, 1'h0, 8'hef);
		test_done;
	end
endmodule
